// ==== ccs_defines.svh ====
// Constants for the clock source select and synthesiser control block.
// Assumes inclusion by bare name from the design files of this block.
`ifndef CCS_DEFINES_SVH
`define CCS_DEFINES_SVH

// ----------------------------------------------------------------------
// Register indices; the byte address on the bus is four times the index.
// ----------------------------------------------------------------------
`define CCS_IDX_CLKS  8'h39
`define CCS_IDX_PLL   8'h3A
`define CCS_IDX_STAT  8'h40

// ----------------------------------------------------------------------
// Reset values and write masks.
// ----------------------------------------------------------------------
`define CCS_CLKS_RST  8'h80
`define CCS_PLL_RST   8'h00
`define CCS_STAT_RST  2'h0
`define CCS_PLL_WMASK 8'h30

// ----------------------------------------------------------------------
// Field positions of the modulation control register.
// ----------------------------------------------------------------------
`define CCS_FM_HI     5
`define CCS_FM_LO     4

// ----------------------------------------------------------------------
// Modulation timing: a 16-cycle reference period, direction flips at 8.
// ----------------------------------------------------------------------
`define CCS_FM_LAST   4'hF
`define CCS_FM_HALF   4'h8
`define CCS_FM_ZERO   4'h0
`define CCS_FM_STEP   4'h1
`define CCS_AMP_OFF   2'h0

`endif

// ==== ccs_pkg.sv ====
// Types shared by the clock source select block and its helpers.
// Assumes nothing of its surroundings; holds definitions only.
package ccs_pkg;

   // -------------------------------------------------------------------
   // Clock source select register layout, bit 7 down to bit 0.
   // -------------------------------------------------------------------
   typedef struct packed {
      logic       sysclk_from_synth;
      logic       osc_runs_in_halt;
      logic [1:0] unused;
      logic       tick_runs_in_light_halt;
      logic       watchdog_runs_in_light_halt;
      logic       tick_clock_from_osc;
      logic       watchdog_clock_from_osc;
   } ccs_clks_t;

   // Status bits gathered into one read-only word.
   typedef struct packed {
      logic lock;
      logic osc_qualified;
   } ccs_stat_t;

   // Modulation amplitude code: off, 1, 2 or 4 percent.
   typedef logic [1:0] ccs_amp_t;

   // Bus slave states.
   typedef enum logic {
      AP_IDLE   = 1'b0,
      AP_ANSWER = 1'b1
   } ccs_ap_state_t;

endpackage : ccs_pkg

// ==== ccs_sync.sv ====
// Three-stage synchroniser for levels from outside the clock domain.
// Assumes a free-running clock; a change passes once stages 2 and 3 agree.
`timescale 1ns/1ps
module ccs_sync #(
   parameter int WIDTH = 2
) (
   input  logic             clk,
   input  logic             rst,
   input  logic             en,
   input  logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] s1;
   logic [WIDTH-1:0] s2;
   logic [WIDTH-1:0] s3;

   // -------------------------------------------------------------------
   // Stages; the first is read only by the second.
   // -------------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s1   <= '0;
         s2   <= '0;
         s3   <= '0;
         dout <= '0;
      end
      else if (en)
      begin
         s1   <= din;
         s2   <= s1;
         s3   <= s2;
         // A bit follows only where the two late stages agree.
         dout <= (s2 & s3) | (dout & (s2 ^ s3));
      end
   end
endmodule : ccs_sync

// ==== ccs_fm.sv ====
// Modulation sweep generator for the synthesiser's oscillator.
// Assumes the reference clock drives it; the amplitude comes from a register.
`timescale 1ns/1ps
`include "ccs_defines.svh"
module ccs_fm (
   input  logic              clk,
   input  logic              rst,
   input  logic              en,
   input  ccs_pkg::ccs_amp_t amp,
   output ccs_pkg::ccs_amp_t amp_out,
   output logic              dir
);
   import ccs_pkg::*;

   logic [3:0] cnt;

   // -------------------------------------------------------------------
   // Sweep at one sixteenth of the reference; idle low when off.
   // -------------------------------------------------------------------
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cnt     <= `CCS_FM_ZERO;
         dir     <= 1'b0;
         amp_out <= `CCS_AMP_OFF;
      end
      else if (en)
      begin
         cnt     <= (cnt == `CCS_FM_LAST) ? `CCS_FM_ZERO : cnt + `CCS_FM_STEP;
         dir     <= (amp != `CCS_AMP_OFF) && (cnt >= `CCS_FM_HALF);
         amp_out <= amp;
      end
   end
endmodule : ccs_fm

// ==== ccs_clock_ctrl.sv ====
// Clock source select and synthesiser control registers behind an APB port.
// Assumes write guard, chip mode, stop and watchdog-write strobes come from
// logic on REF_CLK, and that the two analog status levels are asynchronous.
//
// Functional notes
// - Write guard set blocks clock select writes.
// - Special mode writes every clock select bit.
// - Normal mode writes source, halt, tick bits.
// - Watchdog source locked after watchdog write; rearmable.
// - Bit 7 picks system clock source.
// - Clearing bit 7 needs qualified oscillator.
// - Oscillator loss or full stop sets bit 7.
// - Bit 6 keeps oscillator running in stop.
// - Bit 3 runs tick in light halt.
// - Otherwise tick freezes in stop, count kept.
// - Bit 2 runs watchdog in light halt.
// - Otherwise watchdog freezes in stop, count kept.
// - Bit 1 picks tick clock; change restarts.
// - Tick oscillator source needs qualified oscillator.
// - Bit 0 picks watchdog clock; change restarts.
// - Watchdog oscillator source needs qualified oscillator.
// - Modulation register writable unguarded, synth selected.
// - Accepted modulation write clears both status bits.
// - Two-bit amplitude field, rate reference over 16.
// - Unlocked synthesiser runs at oscillator over four.
// - Qualified status follows oscillator and lock, cleared full stop.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps
`include "ccs_defines.svh"
module ccs_clock_ctrl (
   input  logic              REF_CLK,
   input  logic              RESET,
   input  logic              CLK_EN,
   input  logic              PSEL,
   input  logic              PENABLE,
   input  logic              PWRITE,
   input  logic [11:0]       PADDR,
   input  logic [31:0]       PWDATA,
   output logic [31:0]       PRDATA,
   output logic              PREADY,
   output logic              PSLVERR,
   input  logic              WRITE_GUARD,
   input  logic              SPECIAL_MODE,
   input  logic              STOP_MODE,
   input  logic              WDOG_CTRL_WRITTEN,
   input  logic              OSC_GOOD_PIN,
   input  logic              VCO_IN_TOL_PIN,
   output logic              SYSCLK_FROM_SYNTH,
   output logic              OSC_RUNS_IN_HALT,
   output logic              TICK_CLOCK_FROM_OSC,
   output logic              WDOG_CLOCK_FROM_OSC,
   output logic              TICK_RUN,
   output logic              WDOG_RUN,
   output logic              TICK_RESTART,
   output logic              WDOG_RESTART,
   output logic              SYNTH_DIV4,
   output logic              OSC_QUALIFIED,
   output ccs_pkg::ccs_amp_t VCO_MOD_AMP,
   output logic              VCO_MOD_DIR
);
   import ccs_pkg::*;

   localparam ccs_clks_t CLKS_RST = ccs_clks_t'(`CCS_CLKS_RST);

   ccs_ap_state_t ap_state;
   ccs_ap_state_t next_ap_state;
   ccs_clks_t     clks;
   ccs_clks_t     next_clks;
   ccs_clks_t     wr_val;
   logic [7:0]    pll;
   logic          lock;
   logic          osc_q;
   logic          next_lock;
   logic          next_osc_q;
   logic [1:0]    pin_s;
   logic          stop_d;
   logic          full_stop_entry;
   logic          in_full_stop;
   logic          wd_locked;
   logic          wd_rearm;
   logic          wd_ok;
   logic          commit;
   logic          wr_clks;
   logic          wr_pll;
   logic [31:0]   rdata;
   logic          hit;

   // ---------------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------------
   // True when the byte address selects the register with this index.
   function automatic logic ccs_hit(input logic [11:0] addr,
                                    input logic [7:0]  idx);
      ccs_hit = (addr == {2'b00, idx, 2'b00});
   endfunction : ccs_hit

   // Analog status levels arrive from outside the clock domain.
   ccs_sync #(
      .WIDTH (2)
   ) u_sync (
      .clk  (REF_CLK),
      .rst  (RESET),
      .en   (CLK_EN),
      .din  ({OSC_GOOD_PIN, VCO_IN_TOL_PIN}),
      .dout (pin_s)
   );

   // Modulation sweep runs on the reference clock.
   ccs_fm u_fm (
      .clk     (REF_CLK),
      .rst     (RESET),
      .en      (CLK_EN),
      .amp     (pll[`CCS_FM_HI:`CCS_FM_LO]),
      .amp_out (VCO_MOD_AMP),
      .dir     (VCO_MOD_DIR)
   );

   // ---------------------------------------------------------------------
   // APB slave
   // ---------------------------------------------------------------------
   // One wait state: answers are registered so every output is a flop.
   always_comb
   begin
      case (ap_state)
         AP_IDLE:   next_ap_state = (PSEL && PENABLE) ? AP_ANSWER : AP_IDLE;
         AP_ANSWER: next_ap_state = AP_IDLE;
         default:   next_ap_state = AP_IDLE;
      endcase
   end

   // Write gating resolves within the answering cycle; read data is sampled in the access cycle before it.
   assign commit  = PSEL && PENABLE && PWRITE && (ap_state == AP_ANSWER);
   assign wr_clks = commit && ccs_hit(PADDR, `CCS_IDX_CLKS)
                    && !WRITE_GUARD;
   assign wr_pll  = commit && ccs_hit(PADDR, `CCS_IDX_PLL)
                    && !WRITE_GUARD && clks.sysclk_from_synth;
   assign wr_val  = ccs_clks_t'(PWDATA[7:0]);

   // Read data; unmapped addresses read zero and raise an error.
   always_comb
   begin
      rdata = 32'h0000_0000;
      hit   = 1'b1;
      if (ccs_hit(PADDR, `CCS_IDX_CLKS))
         rdata[7:0] = clks;
      else if (ccs_hit(PADDR, `CCS_IDX_PLL))
         rdata[7:0] = pll;
      else if (ccs_hit(PADDR, `CCS_IDX_STAT))
         rdata[1:0] = {lock, osc_q};
      else
         hit = 1'b0;
   end

   // Bus state and answer registers.
   always_ff @(posedge REF_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         ap_state <= AP_IDLE;
         PREADY   <= 1'b0;
         PSLVERR  <= 1'b0;
         PRDATA   <= 32'h0000_0000;
      end
      else if (CLK_EN)
      begin
         ap_state <= next_ap_state;
         PREADY   <= (next_ap_state == AP_ANSWER);
         PSLVERR  <= (next_ap_state == AP_ANSWER) && !hit;
         if (next_ap_state == AP_ANSWER)
            PRDATA <= rdata;
      end
   end

   // ---------------------------------------------------------------------
   // Stop tracking and status
   // ---------------------------------------------------------------------
   assign full_stop_entry = STOP_MODE && !stop_d && !clks.osc_runs_in_halt;
   assign in_full_stop    = STOP_MODE && !clks.osc_runs_in_halt;

   // A modulation write restarts lock and qualification; here the clear
   // wins over a still-high analog level for that one cycle.
   always_comb
   begin
      next_lock  = pin_s[0] && !wr_pll;
      next_osc_q = pin_s[1] && pin_s[0] && !wr_pll
                   && !in_full_stop && !full_stop_entry;
   end

   always_ff @(posedge REF_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         stop_d <= 1'b0;
         lock   <= 1'b0;
         osc_q  <= 1'b0;
      end
      else if (CLK_EN)
      begin
         stop_d <= STOP_MODE;
         lock   <= next_lock;
         osc_q  <= next_osc_q;
      end
   end

   // ---------------------------------------------------------------------
   // Watchdog source lock
   // ---------------------------------------------------------------------
   // After the watchdog is configured its source is frozen outside special mode, except that a
   // source lost to the oscillator may be restored once.
   assign wd_ok = SPECIAL_MODE || !wd_locked
                  || (wd_rearm && wr_val.watchdog_clock_from_osc);

   always_ff @(posedge REF_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         wd_locked <= 1'b0;
         wd_rearm  <= 1'b0;
      end
      else if (CLK_EN)
      begin
         if (WDOG_CTRL_WRITTEN)
            wd_locked <= 1'b1;
         // Hardware setting wins over a rearm use in the same cycle.
         if (!osc_q && clks.watchdog_clock_from_osc)
            wd_rearm <= 1'b1;
         else if (wr_clks && wd_ok && wr_val.watchdog_clock_from_osc
                  && osc_q && !SPECIAL_MODE)
            wd_rearm <= 1'b0;
      end
   end

   // ---------------------------------------------------------------------
   // Clock source select register
   // ---------------------------------------------------------------------
   always_comb
   begin
      next_clks = clks;
      if (wr_clks)
      begin
         // Synth selection may only drop while the oscillator is good.
         next_clks.sysclk_from_synth = wr_val.sysclk_from_synth
                                       || !osc_q;
         next_clks.osc_runs_in_halt  = wr_val.osc_runs_in_halt;
         next_clks.tick_runs_in_light_halt =
            wr_val.tick_runs_in_light_halt;
         next_clks.watchdog_runs_in_light_halt =
            wr_val.watchdog_runs_in_light_halt;
         next_clks.tick_clock_from_osc =
            wr_val.tick_clock_from_osc && osc_q;
         if (wd_ok)
            next_clks.watchdog_clock_from_osc =
               wr_val.watchdog_clock_from_osc && osc_q;
      end
      if (!osc_q || full_stop_entry)
         next_clks.sysclk_from_synth = 1'b1;
      if (!osc_q)
      begin
         next_clks.tick_clock_from_osc     = 1'b0;
         next_clks.watchdog_clock_from_osc = 1'b0;
      end
      next_clks.unused = 2'b00;
   end

   always_ff @(posedge REF_CLK or posedge RESET)
   begin
      if (RESET)
         clks <= CLKS_RST;
      else if (CLK_EN)
         clks <= next_clks;
   end

   // Modulation control: only the amplitude field is kept.
   always_ff @(posedge REF_CLK or posedge RESET)
   begin
      if (RESET)
         pll <= `CCS_PLL_RST;
      else if (CLK_EN && wr_pll)
         pll <= PWDATA[7:0] & `CCS_PLL_WMASK;
   end

   // ---------------------------------------------------------------------
   // Clock steering outputs
   // ---------------------------------------------------------------------
   // Outputs follow the register's next value so they agree with a read.
   always_ff @(posedge REF_CLK or posedge RESET)
   begin
      if (RESET)
      begin
         SYSCLK_FROM_SYNTH   <= CLKS_RST.sysclk_from_synth;
         OSC_RUNS_IN_HALT    <= CLKS_RST.osc_runs_in_halt;
         TICK_CLOCK_FROM_OSC <= CLKS_RST.tick_clock_from_osc;
         WDOG_CLOCK_FROM_OSC <= CLKS_RST.watchdog_clock_from_osc;
         TICK_RUN            <= 1'b1;
         WDOG_RUN            <= 1'b1;
         TICK_RESTART        <= 1'b0;
         WDOG_RESTART        <= 1'b0;
         SYNTH_DIV4          <= 1'b1;
         OSC_QUALIFIED       <= 1'b0;
      end
      else if (CLK_EN)
      begin
         SYSCLK_FROM_SYNTH   <= next_clks.sysclk_from_synth;
         OSC_RUNS_IN_HALT    <= next_clks.osc_runs_in_halt;
         TICK_CLOCK_FROM_OSC <= next_clks.tick_clock_from_osc;
         WDOG_CLOCK_FROM_OSC <= next_clks.watchdog_clock_from_osc;
         // Counters only gate; a frozen count is kept, never cleared.
         TICK_RUN <= !STOP_MODE || (next_clks.osc_runs_in_halt
                     && next_clks.tick_runs_in_light_halt
                     && next_clks.tick_clock_from_osc);
         WDOG_RUN <= !STOP_MODE || (next_clks.osc_runs_in_halt
                     && next_clks.watchdog_runs_in_light_halt
                     && next_clks.watchdog_clock_from_osc);
         TICK_RESTART <= next_clks.tick_clock_from_osc
                         != clks.tick_clock_from_osc;
         WDOG_RESTART <= next_clks.watchdog_clock_from_osc
                         != clks.watchdog_clock_from_osc;
         SYNTH_DIV4    <= !next_lock;
         OSC_QUALIFIED <= next_osc_q;
      end
   end

   // ---------------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------------
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RESET);

   sequence s_setup;
      CLK_EN && PSEL && !PENABLE;
   endsequence

   sequence s_access;
      CLK_EN && PSEL && PENABLE && !PREADY;
   endsequence

   a_apb_wait_one: assert property (
      s_setup ##1 s_access |=> PREADY)
      else $error("APB answer not given one cycle after access");

   a_guard_blocks_clks: assert property (
      (CLK_EN && commit && WRITE_GUARD && osc_q && !full_stop_entry
       && ccs_hit(PADDR, `CCS_IDX_CLKS)) |=> clks == $past(clks))
      else $error("Guarded clock select write took effect");

   a_pll_write_gate: assert property (
      (CLK_EN && commit && ccs_hit(PADDR, `CCS_IDX_PLL)
       && (WRITE_GUARD || !clks.sysclk_from_synth)) |=> pll == $past(pll))
      else $error("Blocked modulation write took effect");

   a_pll_write_clears: assert property (
      (CLK_EN && wr_pll) |=> !lock && !osc_q ##1 !SYNTH_DIV4 || !lock)
      else $error("Modulation write left status set");

   a_synth_forced_on: assert property (
      (CLK_EN && (!osc_q || full_stop_entry)) |=>
         clks.sysclk_from_synth && SYSCLK_FROM_SYNTH)
      else $error("Synth selection not forced");

   a_osc_src_cleared: assert property (
      (CLK_EN && !osc_q) |=>
         !clks.tick_clock_from_osc && !clks.watchdog_clock_from_osc)
      else $error("Oscillator source kept without qualified oscillator");

   a_tick_restart: assert property (
      (CLK_EN && wr_clks && osc_q
       && wr_val.tick_clock_from_osc != clks.tick_clock_from_osc)
      |=> TICK_RESTART && $changed(clks.tick_clock_from_osc))
      else $error("Tick source change gave no restart");

   a_wdog_src_locked: assert property (
      (CLK_EN && wr_clks && wd_locked && !wd_rearm && !SPECIAL_MODE
       && osc_q) |=> $stable(clks.watchdog_clock_from_osc))
      else $error("Locked watchdog source changed");

   a_tick_frozen: assert property (
      (CLK_EN && STOP_MODE && !next_clks.tick_clock_from_osc) |=> !TICK_RUN)
      else $error("Tick ran in stop without oscillator source");

   a_wdog_frozen: assert property (
      (CLK_EN && STOP_MODE && !next_clks.watchdog_runs_in_light_halt)
      |=> !WDOG_RUN)
      else $error("Watchdog ran in stop while disabled");

endmodule : ccs_clock_ctrl

// ==== ccs_clock_ctrl_tb.sv ====
// Self-checking bench for the clock source select and modulation block.
// Assumes the package and design files are compiled first; the bench is
// the only APB master and drives every status and mode input itself.
`timescale 1ns/1ps
`include "ccs_defines.svh"
module ccs_clock_ctrl_tb;
   import ccs_pkg::*;
   // ----------------------------------------------------------------
   // Stimulus and observed signals.
   // ----------------------------------------------------------------
   logic        clk = 0, rst = 1, sel = 0, en = 0, wr = 0;
   logic [11:0] addr = '0;
   logic [31:0] wdat = '0, rdat;
   logic        guard = 0, spec = 0, stp = 0, wdw = 0, osc = 0, tol = 0;
   logic        ce = 1;
   logic        rdy, err, lerr, sys, halt, tosc, wosc, trun, wrun;
   logic        trs, wrs, div4, oq, dir;
   ccs_amp_t    amp;
   int          fails = 0, samples_checked = 0;

   ccs_clock_ctrl dut (
      .REF_CLK(clk), .RESET(rst), .CLK_EN(ce), .PSEL(sel),
      .PENABLE(en), .PWRITE(wr), .PADDR(addr), .PWDATA(wdat),
      .PRDATA(rdat), .PREADY(rdy), .PSLVERR(err), .WRITE_GUARD(guard),
      .SPECIAL_MODE(spec), .STOP_MODE(stp), .WDOG_CTRL_WRITTEN(wdw),
      .OSC_GOOD_PIN(osc), .VCO_IN_TOL_PIN(tol), .SYSCLK_FROM_SYNTH(sys),
      .OSC_RUNS_IN_HALT(halt), .TICK_CLOCK_FROM_OSC(tosc),
      .WDOG_CLOCK_FROM_OSC(wosc), .TICK_RUN(trun), .WDOG_RUN(wrun),
      .TICK_RESTART(trs), .WDOG_RESTART(wrs), .SYNTH_DIV4(div4),
      .OSC_QUALIFIED(oq), .VCO_MOD_AMP(amp), .VCO_MOD_DIR(dir));

   // Free-running 200 MHz clock.
   initial
   begin
      forever #2.5 clk = ~clk;
   end

   // ----------------------------------------------------------------
   // Shared tasks.
   // ----------------------------------------------------------------
   // Prints the counts and the verdict, then ends the run.
   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : summarize

   // Compares one value; unknown bits never pass.
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      samples_checked++;
      if (got !== exp)
      begin
         fails++;
         $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // One APB transfer; returns just after the edge that completes it.
   task automatic apb(input logic w, input logic [7:0] idx,
                      input logic [7:0] d);
      int n;
      @(posedge clk);
      sel  <= 1'b1;
      en   <= 1'b0;
      wr   <= w;
      addr <= {2'b00, idx, 2'b00};
      wdat <= {24'h00_0000, d};
      @(posedge clk);
      en <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (rdy !== 1'b1 && n < 16);
      lerr = err;
      sel <= 1'b0;
      en  <= 1'b0;
      if (rdy !== 1'b1)
      begin
         fails++;
         $display("[ERR] %0t bus answer missing", $time);
         summarize();
      end
      else
         #1;
   endtask : apb

   // Reads a register and compares its value.
   task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 8'h00);
      chk(rdat, exp, "read data");
   endtask : rd

   // ----------------------------------------------------------------
   // Scenarios.
   // ----------------------------------------------------------------
   // Reset values, an unmapped place, status after the pins qualify.
   task automatic t_reset();
      rd(`CCS_IDX_CLKS, 32'h0000_0080);
      chk(sys, 1'b1, "sysclk after reset");
      chk(div4, 1'b1, "div4 while unlocked");
      rd(`CCS_IDX_PLL, 32'h0000_0000);
      rd(8'h10, 32'h0000_0000);
      chk(lerr, 1'b1, "unmapped error");
      @(posedge clk);
      osc <= 1'b1;
      tol <= 1'b1;
      repeat (10) @(posedge clk);
      rd(`CCS_IDX_STAT, 32'h0000_0003);
      chk(div4, 1'b0, "div4 when locked");
      $display("test reset done");
   endtask : t_reset

   // Guarded writes are dropped, then a normal mode write lands.
   task automatic t_write();
      @(posedge clk);
      guard <= 1'b1;
      apb(1'b1, `CCS_IDX_CLKS, 8'h4F);
      rd(`CCS_IDX_CLKS, 32'h0000_0080);
      apb(1'b1, `CCS_IDX_PLL, 8'h30);
      rd(`CCS_IDX_PLL, 32'h0000_0000);
      @(posedge clk);
      guard <= 1'b0;
      apb(1'b1, `CCS_IDX_CLKS, 8'h4F);
      chk(trs, 1'b1, "tick restart");
      chk(wrs, 1'b1, "watchdog restart");
      chk(sys, 1'b0, "sysclk from crystal");
      chk(halt, 1'b1, "oscillator kept in halt");
      rd(`CCS_IDX_CLKS, 32'h0000_004F);
      apb(1'b1, `CCS_IDX_PLL, 8'h10);
      rd(`CCS_IDX_PLL, 32'h0000_0000);
      $display("test write done");
   endtask : t_write

   // Watchdog source locks after its control write; special mode frees it.
   task automatic t_wdog();
      @(posedge clk);
      wdw <= 1'b1;
      @(posedge clk);
      wdw <= 1'b0;
      apb(1'b1, `CCS_IDX_CLKS, 8'h4E);
      rd(`CCS_IDX_CLKS, 32'h0000_004F);
      @(posedge clk);
      spec <= 1'b1;
      apb(1'b1, `CCS_IDX_CLKS, 8'h4E);
      rd(`CCS_IDX_CLKS, 32'h0000_004E);
      apb(1'b1, `CCS_IDX_CLKS, 8'h4F);
      @(posedge clk);
      spec <= 1'b0;
      $display("test watchdog done");
   endtask : t_wdog

   // Stop with every run condition set keeps counters running; clearing each light-halt bit freezes its counter.
   task automatic t_stop();
      @(posedge clk);
      stp <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk(trun, 1'b1, "tick runs in halt");
      chk(wrun, 1'b1, "watchdog runs in halt");
      apb(1'b1, `CCS_IDX_CLKS, 8'h4B);
      chk(wrun, 1'b0, "watchdog frozen");
      apb(1'b1, `CCS_IDX_CLKS, 8'h43);
      chk(trun, 1'b0, "tick frozen");
      @(posedge clk);
      stp <= 1'b0;
      $display("test stop done");
   endtask : t_stop

   // Every amplitude code, the status clear and the 16-cycle sweep.
   task automatic t_fm();
      int   n;
      logic prev;
      apb(1'b1, `CCS_IDX_CLKS, 8'hC3);
      for (int a = 0; a < 4; a++)
      begin
         apb(1'b1, `CCS_IDX_PLL, {2'b00, a[1:0], 4'h0});
         chk(oq, 1'b0, "status cleared");
         rd(`CCS_IDX_PLL, {26'h0, a[1:0], 4'h0});
         chk(amp, a[1:0], "amplitude");
         prev = dir;
         n = 0;
         repeat (32)
         begin
            @(posedge clk);
            #1;
            n += (dir !== prev);
            prev = dir;
         end
         chk(n, (a == 0) ? 0 : 4, "sweep edges");
      end
      // With the enable low the running sweep must not move.
      @(posedge clk);
      ce <= 1'b0;
      #1;
      prev = dir;
      repeat (20) @(posedge clk);
      #1;
      chk(dir, prev, "sweep frozen");
      @(posedge clk);
      ce <= 1'b1;
      $display("test modulation done");
   endtask : t_fm

   // Oscillator loss, refused writes, rearm and full stop entry.
   task automatic t_loss();
      repeat (8) @(posedge clk);
      apb(1'b1, `CCS_IDX_CLKS, 8'h4F);
      @(posedge clk);
      osc <= 1'b0;
      repeat (8) @(posedge clk);
      #1;
      chk(sys, 1'b1, "sysclk forced");
      chk(tosc, 1'b0, "tick source cleared");
      chk(wosc, 1'b0, "watchdog source cleared");
      chk(oq, 1'b0, "qualified low");
      apb(1'b1, `CCS_IDX_CLKS, 8'h03);
      rd(`CCS_IDX_CLKS, 32'h0000_0080);
      @(posedge clk);
      osc <= 1'b1;
      repeat (8) @(posedge clk);
      apb(1'b1, `CCS_IDX_CLKS, 8'h01);
      rd(`CCS_IDX_CLKS, 32'h0000_0001);
      apb(1'b1, `CCS_IDX_CLKS, 8'h00);
      rd(`CCS_IDX_CLKS, 32'h0000_0001);
      @(posedge clk);
      stp <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      chk(sys, 1'b1, "full stop sysclk");
      chk(oq, 1'b0, "full stop qualified");
      chk(trun, 1'b0, "tick frozen in full stop");
      $display("test loss done");
   endtask : t_loss

   // Main sequence.
   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      t_reset();
      t_write();
      t_wdog();
      t_stop();
      t_fm();
      t_loss();
      summarize();
   end
endmodule : ccs_clock_ctrl_tb
